//--- rfw_defs.svh
// Offsets, field positions, reset values and wake-up timing for the reset flag block
// Assumes a 125 MHz clock and byte addresses on a 32-bit APB
`ifndef RFW_DEFS_SVH
`define RFW_DEFS_SVH

`define RFW_OFS_FLAGS   8'h00
`define RFW_OFS_CORE    8'h04
`define RFW_OFS_CTRL    8'h08
`define RFW_OFS_TOS     8'h0C
`define RFW_OFS_HW_STACK_POINTER  8'h10
`define RFW_OFS_INTF    8'h14
`define RFW_OFS_STORE0  8'h18
`define RFW_OFS_STORE1  8'h1C

`define RFW_FLAG_BOR    3
`define RFW_FLAG_MPOR   2
`define RFW_FLAG_BPOR   1
`define RFW_FLAG_BEXIT  0
`define RFW_CORE_POR    0
`define RFW_CORE_WDT    1
`define RFW_CTRL_RET    0
`define RFW_CTRL_SMALL  1
`define RFW_CTRL_OSC    2

`define RFW_PIN_BOR     0
`define RFW_PIN_MPOR    1
`define RFW_PIN_BPOR    2
`define RFW_PIN_CPOR    3
`define RFW_PIN_BEXIT   4
`define RFW_PIN_BATT    5
`define RFW_PIN_COUNT   6

`define RFW_INTF_RST    8'h00
`define RFW_INTF_FULL   8'hFF
`define RFW_INTF_SMALL  8'h3F
`define RFW_VEC_HIGH    21'h0_0008
`define RFW_VEC_LOW     21'h0_0018

`define RFW_CLK_NS      8
`define RFW_OSC0_NS     64
`define RFW_OSC1_NS     1000
`define RFW_OSC2_NS     2000
`define RFW_OSC3_NS     4000
`define RFW_REG_NORM_NS 200
`define RFW_REG_RET_NS  800
`define RFW_CYC(ns)     16'(((ns) + `RFW_CLK_NS - 1) / `RFW_CLK_NS)

`endif

//--- rfw_pkg.sv
// Types shared by the reset flag and wake-up block
// Assumes rfw_defs.svh for all numeric values
package rfw_pkg;

	typedef enum logic [1:0] {
		RFW_RUN   = 2'b00,
		RFW_SLEEP = 2'b01,
		RFW_DELAY = 2'b10
	} rfw_wake_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} rfw_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} rfw_apb_rsp_t;

	typedef struct packed {
		logic        sleepReq;
		logic        otherReset;
		logic        wdtTimeout;
		logic [7:0]  intSet;
		logic        intHighPrio;
		logic        global_high_prio_int_enable;
		logic        global_low_prio_int_enable;
		logic [20:0] pcCurrent;
	} rfw_core_req_t;

	typedef struct packed {
		logic        coreHold;
		logic        pcLoadValid;
		logic        vectorTaken;
		logic [20:0] pcLoadAddr;
	} rfw_core_rsp_t;

	typedef struct packed {
		rfw_wake_t   wake;
		logic        retSleep;
		logic        irqWake;
		logic        irqHigh;
		logic        firstDone;
		logic        batteryKept;
		logic [3:0]  power_domain_reset_flags;
		logic [1:0]  coreFlags;
		logic [3:0]  ctrl;
		logic [20:0] stack_top;
		logic [4:0]  hw_stack_pointer;
		logic [7:0]  interrupt_control_regs;
		logic [7:0]  store0;
		logic [7:0]  store1;
		rfw_core_rsp_t core;
		rfw_apb_rsp_t  apb;
	} rfw_state_t;

endpackage : rfw_pkg

//--- rfw_sync.sv
// Three-stage synchroniser for supervisor pins, with event pulses
// Assumes pins are asynchronous to clk
`timescale 1ns/10ps
module rfw_sync #(
	parameter int WIDTH = 6
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pins,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
		logic [WIDTH-1:0] rise;
	} rfw_sync_state_t;

	rfw_sync_state_t s;
	rfw_sync_state_t next_s;
	logic [WIDTH-1:0] next_level;

	////////////////////////////////////////////////////////////////////////
	// Level changes only once the two late stages agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			assign next_level[i] = (s.s2[i] == s.s3[i]) ? s.s3[i] : s.level[i];
		end
	endgenerate

	always_comb
	begin
		next_s       = s;
		next_s.s1    = pins;
		next_s.s2    = s.s1;
		next_s.s3    = s.s2;
		next_s.level = next_level;
		next_s.rise  = next_level & ~s.level;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign level = s.level;
	assign rise  = s.rise;
endmodule : rfw_sync

//--- rfw_wake_timer.sv
// Down-counter that times the wake-up delay
// Assumes load is a single-cycle pulse from the same clock
`timescale 1ns/10ps
module rfw_wake_timer #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] loadValue,
	output logic                  busy,
	output logic                  done
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic             busy;
		logic             done;
	} rfw_timer_state_t;

	rfw_timer_state_t s;
	rfw_timer_state_t next_s;

	always_comb
	begin
		next_s      = s;
		next_s.done = 1'b0;
		if (load)
		begin
			next_s.count = loadValue;
			next_s.busy  = 1'b1;
		end
		else if (s.busy)
		begin
			if (s.count <= WIDTH'(1))
			begin
				next_s.busy  = 1'b0;
				next_s.done  = 1'b1;
				next_s.count = '0;
			end
			else
				next_s.count = s.count - WIDTH'(1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign busy = s.busy;
	assign done = s.done;
endmodule : rfw_wake_timer

//--- rfw_reset_flags.sv
// Power-domain reset flags, register initialisation per reset cause and wake-up sequencing
// Assumes an APB master on clk, core signals on clk, supervisor pins asynchronous
//
// Contract
// - Same clock start-up delay for both sleeps
// - Add regulator switchover delay per sleep type
// - Separate main-supply and core power-on flags
// - Battery power-on flag set at first power-up
// - Interrupt wake with enables pushes PC
// - Interrupt wake with enables advances the stack pointer
// - Interrupt wake with enables loads high or low vector
// - Wake-causing interrupt bits stay set
// - Small package: upper two bits read zero
// - Battery kept: storage survives later power-ons
// - Unimplemented bits read zero, unchanged bits kept
// - Enables clear: continue after sleep instruction
`timescale 1ns/10ps
`include "rfw_defs.svh"
module rfw_reset_flags
	import rfw_pkg::*;
#(
	parameter int          TIMER_WIDTH = 16,
	parameter logic [15:0] OSC0_CYC    = `RFW_CYC(`RFW_OSC0_NS),
	parameter logic [15:0] OSC1_CYC    = `RFW_CYC(`RFW_OSC1_NS),
	parameter logic [15:0] OSC2_CYC    = `RFW_CYC(`RFW_OSC2_NS),
	parameter logic [15:0] OSC3_CYC    = `RFW_CYC(`RFW_OSC3_NS),
	parameter logic [15:0] REG_NORM    = `RFW_CYC(`RFW_REG_NORM_NS),
	parameter logic [15:0] REG_RET     = `RFW_CYC(`RFW_REG_RET_NS)
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire rfw_apb_req_t              apbReq,
	output rfw_apb_rsp_t                   apbRsp,
	input  wire logic [`RFW_PIN_COUNT-1:0] supplyPins,
	input  wire rfw_core_req_t             coreReq,
	output rfw_core_rsp_t                  coreRsp
);
	rfw_state_t s;
	rfw_state_t next_s;

	logic [`RFW_PIN_COUNT-1:0] pinLevel;
	logic [`RFW_PIN_COUNT-1:0] pinRise;
	logic                      timerLoad;
	logic [15:0]               timerValue;
	logic                      timerBusy;
	logic                      timerDone;
	logic [31:0]               readValue;
	logic                      mapped;
	logic [7:0]                intMask;
	logic [15:0]               oscCycles;
	logic                      gieAny;

	////////////////////////////////////////////////////////////////////////
	// Supervisor pins and wake timer
	rfw_sync #(
		.WIDTH(`RFW_PIN_COUNT)
	) u_sync (
		.clk  (clk),
		.rst  (rst),
		.pins (supplyPins),
		.level(pinLevel),
		.rise (pinRise)
	);

	rfw_wake_timer #(
		.WIDTH(TIMER_WIDTH)
	) u_timer (
		.clk      (clk),
		.rst      (rst),
		.load     (timerLoad),
		.loadValue(timerValue[TIMER_WIDTH-1:0]),
		.busy     (timerBusy),
		.done     (timerDone)
	);

	////////////////////////////////////////////////////////////////////////
	// Read decode
	// upper bits masked
	assign intMask = s.ctrl[`RFW_CTRL_SMALL] ? `RFW_INTF_SMALL : `RFW_INTF_FULL;
	assign gieAny  = coreReq.global_high_prio_int_enable | coreReq.global_low_prio_int_enable;

	always_comb
	begin
		readValue = '0;
		mapped    = 1'b1;
		unique case (apbReq.paddr)
			`RFW_OFS_FLAGS:  readValue[3:0]  = s.power_domain_reset_flags;
			`RFW_OFS_CORE:   readValue[1:0]  = s.coreFlags;
			`RFW_OFS_CTRL:   readValue[3:0]  = s.ctrl;
			`RFW_OFS_TOS:    readValue[20:0] = s.stack_top;
			`RFW_OFS_HW_STACK_POINTER: readValue[4:0]  = s.hw_stack_pointer;
			`RFW_OFS_INTF:   readValue[7:0]  = s.interrupt_control_regs & intMask;
			`RFW_OFS_STORE0: readValue[7:0]  = s.store0;
			`RFW_OFS_STORE1: readValue[7:0]  = s.store1;
			default:         mapped          = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Wake delay selection
	always_comb
	begin
		unique case (s.ctrl[`RFW_CTRL_OSC +: 2])
			2'b00: oscCycles = OSC0_CYC;
			2'b01: oscCycles = OSC1_CYC;
			2'b10: oscCycles = OSC2_CYC;
			2'b11: oscCycles = OSC3_CYC;
		endcase
		timerValue = oscCycles + (s.retSleep ? REG_RET : REG_NORM);
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		next_s                  = s;
		next_s.core.pcLoadValid = 1'b0;
		next_s.core.vectorTaken = 1'b0;
		timerLoad               = 1'b0;

		// Bus slave: one wait-free access phase after setup
		next_s.apb.pready = apbReq.psel & ~apbReq.penable;
		if (apbReq.psel & ~apbReq.penable)
		begin
			next_s.apb.prdata  = readValue;
			next_s.apb.pslverr = ~mapped;
		end
		if (apbReq.psel & apbReq.penable & s.apb.pready & apbReq.pwrite & ~s.apb.pslverr)
		begin
			unique case (apbReq.paddr)
				`RFW_OFS_FLAGS:
				begin
					next_s.power_domain_reset_flags[3:1] = s.power_domain_reset_flags[3:1] & apbReq.pwdata[3:1];
					next_s.power_domain_reset_flags[0]   = apbReq.pwdata[0];
				end
				`RFW_OFS_CORE:   next_s.coreFlags              = s.coreFlags & apbReq.pwdata[1:0];
				`RFW_OFS_CTRL:   next_s.ctrl                   = apbReq.pwdata[3:0];
				`RFW_OFS_TOS:    next_s.stack_top              = apbReq.pwdata[20:0];
				`RFW_OFS_HW_STACK_POINTER: next_s.hw_stack_pointer       = apbReq.pwdata[4:0];
				`RFW_OFS_INTF:   next_s.interrupt_control_regs = apbReq.pwdata[7:0] & intMask;
				`RFW_OFS_STORE0: next_s.store0                 = apbReq.pwdata[7:0];
				`RFW_OFS_STORE1: next_s.store1                 = apbReq.pwdata[7:0];
				default:         next_s.store1                 = s.store1;
			endcase
		end

		if (pinRise[`RFW_PIN_BOR])
			next_s.power_domain_reset_flags[`RFW_FLAG_BOR] = 1'b1;
		if (pinRise[`RFW_PIN_BEXIT])
			next_s.power_domain_reset_flags[`RFW_FLAG_BEXIT] = 1'b1;
		if (pinRise[`RFW_PIN_MPOR])
			next_s.power_domain_reset_flags[`RFW_FLAG_MPOR] = 1'b1;
		if (pinRise[`RFW_PIN_CPOR])
			next_s.coreFlags[`RFW_CORE_POR] = 1'b1;
		if (pinRise[`RFW_PIN_BPOR] | (pinRise[`RFW_PIN_MPOR] & ~s.firstDone))
			next_s.power_domain_reset_flags[`RFW_FLAG_BPOR] = 1'b1;
		next_s.interrupt_control_regs = next_s.interrupt_control_regs | (coreReq.intSet & intMask);

		// Battery continuity since first power-on
		if (~pinLevel[`RFW_PIN_BATT])
			next_s.batteryKept = 1'b0;

		// Wake sequencing
		unique case (s.wake)
			RFW_RUN:
			begin
				if (coreReq.sleepReq)
				begin
					next_s.wake          = RFW_SLEEP;
					next_s.retSleep      = s.ctrl[`RFW_CTRL_RET];
					next_s.core.coreHold = 1'b1;
				end
			end
			RFW_SLEEP:
			begin
				if (|coreReq.intSet)
				begin
					next_s.wake    = RFW_DELAY;
					next_s.irqWake = 1'b1;
					next_s.irqHigh = coreReq.intHighPrio;
					timerLoad      = 1'b1;
				end
				else if (coreReq.wdtTimeout)
				begin
					next_s.wake                     = RFW_DELAY;
					next_s.irqWake                  = 1'b0;
					next_s.coreFlags[`RFW_CORE_WDT] = 1'b1;
					timerLoad                       = 1'b1;
				end
			end
			RFW_DELAY:
			begin
				if (timerDone)
				begin
					next_s.wake             = RFW_RUN;
					next_s.core.coreHold    = 1'b0;
					next_s.core.pcLoadValid = 1'b1;
					if (s.irqWake & gieAny)
					begin
						next_s.stack_top        = coreReq.pcCurrent;
						next_s.hw_stack_pointer = s.hw_stack_pointer + 5'h01;
						next_s.core.pcLoadAddr  = s.irqHigh ? `RFW_VEC_HIGH : `RFW_VEC_LOW;
						next_s.core.vectorTaken = 1'b1;
					end
					else
						next_s.core.pcLoadAddr = coreReq.pcCurrent;
				end
			end
			default: next_s.wake = RFW_RUN;
		endcase

		if (coreReq.otherReset)
		begin
			next_s.wake                   = RFW_RUN;
			next_s.core                   = '0;
			next_s.stack_top              = '0;
			next_s.hw_stack_pointer       = '0;
			next_s.interrupt_control_regs = `RFW_INTF_RST;
		end
		if (pinRise[`RFW_PIN_MPOR])
		begin
			next_s.wake                   = RFW_RUN;
			next_s.core                   = '0;
			next_s.ctrl                   = '0;
			next_s.stack_top              = '0;
			next_s.hw_stack_pointer       = '0;
			next_s.interrupt_control_regs = `RFW_INTF_RST;
			next_s.firstDone              = 1'b1;
			if (~s.firstDone)
				next_s.batteryKept = pinLevel[`RFW_PIN_BATT];
			if (~(s.firstDone & s.batteryKept & pinLevel[`RFW_PIN_BATT]))
			begin
				next_s.store0 = '0;
				next_s.store1 = '0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign apbRsp  = s.apb;
	assign coreRsp = s.core;

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_delay_sum;
		@(posedge clk) disable iff (rst)
		timerLoad |-> timerValue == (s.ctrl[`RFW_CTRL_OSC +: 2] == 2'b00 ? OSC0_CYC
			: s.ctrl[`RFW_CTRL_OSC +: 2] == 2'b01 ? OSC1_CYC
			: s.ctrl[`RFW_CTRL_OSC +: 2] == 2'b10 ? OSC2_CYC : OSC3_CYC)
			+ (s.retSleep ? REG_RET : REG_NORM);
	endproperty
	a_delay_sum: assert property (p_delay_sum) else $error("wake delay sum wrong");

	property p_same_osc;
		@(posedge clk) disable iff (rst)
		timerLoad && s.ctrl[`RFW_CTRL_OSC +: 2] == 2'b00 |-> timerValue - (s.retSleep ? REG_RET : REG_NORM) == OSC0_CYC;
	endproperty
	a_same_osc: assert property (p_same_osc) else $error("clock start-up differs by sleep type");

	property p_mpor_flag;
		@(posedge clk) disable iff (rst)
		pinRise[`RFW_PIN_MPOR] && !s.firstDone
		|=> s.power_domain_reset_flags[`RFW_FLAG_MPOR] && s.power_domain_reset_flags[`RFW_FLAG_BPOR];
	endproperty
	a_mpor_flag: assert property (p_mpor_flag) else $error("first power-up flags missing");

	property p_core_flag;
		@(posedge clk) disable iff (rst)
		pinRise[`RFW_PIN_CPOR] |=> s.coreFlags[`RFW_CORE_POR];
	endproperty
	a_core_flag: assert property (p_core_flag) else $error("core power-on flag not set");

	property p_push;
		@(posedge clk) disable iff (rst)
		s.wake == RFW_DELAY && timerDone && s.irqWake && gieAny && !coreReq.otherReset && !pinRise[`RFW_PIN_MPOR]
		|=> s.stack_top == $past(coreReq.pcCurrent) && s.hw_stack_pointer == $past(s.hw_stack_pointer) + 5'h01;
	endproperty
	a_push: assert property (p_push) else $error("push on interrupt wake wrong");

	property p_vector;
		@(posedge clk) disable iff (rst)
		coreRsp.vectorTaken |-> coreRsp.pcLoadValid && coreRsp.coreHold == 1'b0
			&& coreRsp.pcLoadAddr == ($past(s.irqHigh) ? `RFW_VEC_HIGH : `RFW_VEC_LOW);
	endproperty
	a_vector: assert property (p_vector) else $error("vector address wrong");

	property p_no_vector;
		@(posedge clk) disable iff (rst)
		s.wake == RFW_DELAY && timerDone && !gieAny && !coreReq.otherReset && !pinRise[`RFW_PIN_MPOR]
		|=> coreRsp.pcLoadValid && !coreRsp.vectorTaken && coreRsp.pcLoadAddr == $past(coreReq.pcCurrent);
	endproperty
	a_no_vector: assert property (p_no_vector) else $error("vectored with enables clear");

	property p_small_pkg;
		@(posedge clk) disable iff (rst)
		apbRsp.pready && s.ctrl[`RFW_CTRL_SMALL] && apbReq.paddr == `RFW_OFS_INTF |-> apbRsp.prdata[7:6] == 2'b00;
	endproperty
	a_small_pkg: assert property (p_small_pkg) else $error("upper interrupt bits not zero");

	property p_flag_sticky;
		@(posedge clk) disable iff (rst)
		s.power_domain_reset_flags[`RFW_FLAG_BOR] && !(apbReq.psel && apbReq.penable && apbReq.pwrite)
		|=> s.power_domain_reset_flags[`RFW_FLAG_BOR];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("brown-out flag lost");

	property p_wake_bits;
		@(posedge clk) disable iff (rst)
		s.wake == RFW_SLEEP && |(coreReq.intSet & intMask) && !coreReq.otherReset && !pinRise[`RFW_PIN_MPOR]
		|=> (s.interrupt_control_regs & $past(coreReq.intSet & intMask)) == $past(coreReq.intSet & intMask);
	endproperty
	a_wake_bits: assert property (p_wake_bits) else $error("wake source bit lost");

	property p_storage_kept;
		@(posedge clk) disable iff (rst)
		pinRise[`RFW_PIN_MPOR] && s.firstDone && s.batteryKept && pinLevel[`RFW_PIN_BATT]
		&& !(apbReq.psel && apbReq.penable && apbReq.pwrite) |=> $stable(s.store0) && $stable(s.store1);
	endproperty
	a_storage_kept: assert property (p_storage_kept) else $error("storage lost under battery");

	property p_warm_reset;
		@(posedge clk) disable iff (rst)
		coreReq.otherReset |=> s.wake == RFW_RUN && !coreRsp.coreHold && !coreRsp.pcLoadValid
			&& s.hw_stack_pointer == 5'h00 && s.stack_top == 21'h0_0000
			&& s.interrupt_control_regs == `RFW_INTF_RST;
	endproperty
	a_warm_reset: assert property (p_warm_reset) else $error("warm reset values wrong");
endmodule : rfw_reset_flags

//--- rfw_core_model.sv
// Model of the processor core and supply supervisors facing the block
// Assumes the bench calls its tasks from code synchronous to clk
`timescale 1ns/10ps
`include "rfw_defs.svh"
module rfw_core_model
	import rfw_pkg::*;
(
	input  wire logic                 clk,
	output rfw_core_req_t             coreReq,
	output logic [`RFW_PIN_COUNT-1:0] supplyPins
);

	initial
	begin
		coreReq    = '0;
		supplyPins = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// drive one supervisor pin level; a rising level sets its flag (the battery pin has none)
	task automatic pin(input int idx, input logic lvl);
		@(posedge clk);
		supplyPins[idx] <= lvl;
		repeat (6) @(posedge clk);
	endtask : pin

	task automatic pulse_pin(input int idx);
		pin(idx, 1'b0);
		pin(idx, 1'b1);
	endtask : pulse_pin

	////////////////////////////////////////////////////////////////////////
	// one-cycle warm reset
	task automatic warm_reset();
		@(posedge clk);
		coreReq.otherReset <= 1'b1;
		@(posedge clk);
		coreReq.otherReset <= 1'b0;
	endtask : warm_reset

	////////////////////////////////////////////////////////////////////////
	// Sleep, then one wake event; returns just after the waking edge
	task automatic sleep_wake(input logic [7:0] bits, input logic hi, input logic geh, input logic gel,
		input logic [20:0] pc, input logic wdt);
		@(posedge clk);
		coreReq.sleepReq                    <= 1'b1;
		coreReq.pcCurrent                   <= pc;
		coreReq.global_high_prio_int_enable <= geh;
		coreReq.global_low_prio_int_enable  <= gel;
		@(posedge clk);
		coreReq.sleepReq <= 1'b0;
		repeat (2) @(posedge clk);
		coreReq.wdtTimeout  <= wdt;
		coreReq.intSet      <= wdt ? 8'h00 : bits;
		coreReq.intHighPrio <= hi;
		@(posedge clk);
		coreReq.wdtTimeout <= 1'b0;
		coreReq.intSet     <= 8'h00;
	endtask : sleep_wake

endmodule : rfw_core_model

//--- reset_flags_wake_init_tb_top.sv
// Self-checking bench for the reset flag and wake-up block
// Assumes short wake-up timing parameters set below
`timescale 1ns/10ps
`include "rfw_defs.svh"
module reset_flags_wake_init_tb_top
	import rfw_pkg::*;
;
	localparam logic [15:0] OSC_T [4] = '{16'h0004, 16'h0005, 16'h0006, 16'h0007};
	localparam logic [15:0] REG_N     = 16'h0002;
	localparam logic [15:0] REG_R     = 16'h0003;

	logic                      clk             = 1'b0;
	logic                      rst             = 1'b1;
	rfw_apb_req_t              apbReq          = '0;
	rfw_apb_rsp_t              apbRsp;
	rfw_core_req_t             coreReq;
	rfw_core_rsp_t             coreRsp;
	logic [`RFW_PIN_COUNT-1:0] supplyPins;
	logic [31:0]               lfsr            = 32'h6d2f_a757;
	int                        failures        = 0;
	int                        samples_checked = 0;

	always #4 clk = ~clk;

	rfw_reset_flags #(
		.OSC0_CYC (OSC_T[0]),
		.OSC1_CYC (OSC_T[1]),
		.OSC2_CYC (OSC_T[2]),
		.OSC3_CYC (OSC_T[3]),
		.REG_NORM (REG_N),
		.REG_RET  (REG_R)
	) i_dut (
		.clk        (clk),
		.rst        (rst),
		.apbReq     (apbReq),
		.apbRsp     (apbRsp),
		.supplyPins (supplyPins),
		.coreReq    (coreReq),
		.coreRsp    (coreRsp)
	);

	rfw_core_model i_core (
		.clk        (clk),
		.coreReq    (coreReq),
		.supplyPins (supplyPins)
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd

	function automatic logic [31:0] exp_wake(input int osc, input int ret);
		return 32'(OSC_T[osc]) + 32'(ret ? REG_R : REG_N) + 32'd2;
	endfunction : exp_wake

	function automatic logic [31:0] vec(input logic hi);
		return {11'h000, hi ? `RFW_VEC_HIGH : `RFW_VEC_LOW};
	endfunction : vec

	task automatic print_verdict();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic bound(input int n, input int lim);
		if (n > lim)
		begin
			failures++;
			$display("unexpected at %0t: wait ran out", $time);
			print_verdict();
		end
	endtask : bound

	////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		apbReq.psel    <= 1'b1;
		apbReq.penable <= 1'b0;
		apbReq.pwrite  <= wr;
		apbReq.paddr   <= a;
		apbReq.pwdata  <= wd;
		@(posedge clk);
		apbReq.penable <= 1'b1;
		for (n = 1; n <= 20; n++)
		begin
			@(posedge clk);
			if (apbRsp.pready === 1'b1)
				break;
		end
		bound(n, 20);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel    <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		check(r, exp, what);
	endtask : rdchk

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		int          i;
		int          n;
		int          osc;
		int          ret;
		int          mode;
		logic [31:0] d;
		logic [31:0] pc;
		logic [31:0] sp;
		logic [31:0] bits;
		logic        e;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 8; i++)
			rdchk(8'(i * 4), 32'h0000_0000, "reset value");
		apb(1'b0, 8'h20, 32'h0000_0000, d, e);
		check(e, 1'b1, "unmapped error");
		check(d, 32'h0000_0000, "unmapped data");
		i_core.pin(`RFW_PIN_BATT, 1'b1);
		i_core.pin(`RFW_PIN_MPOR, 1'b1);
		rdchk(`RFW_OFS_FLAGS, 32'h0000_0006, "first power-on");
		i_core.pin(`RFW_PIN_CPOR, 1'b1);
		rdchk(`RFW_OFS_CORE, 32'h0000_0001, "core power-on");
		i_core.pin(`RFW_PIN_BOR, 1'b1);
		i_core.pin(`RFW_PIN_BEXIT, 1'b1);
		rdchk(`RFW_OFS_FLAGS, 32'h0000_000F, "all flags");
		wr(`RFW_OFS_FLAGS, 32'h0000_0008);
		rdchk(`RFW_OFS_FLAGS, 32'h0000_0008, "clear by zero");
		wr(`RFW_OFS_FLAGS, 32'h0000_0001);
		rdchk(`RFW_OFS_FLAGS, 32'h0000_0001, "exit bit written");
		wr(`RFW_OFS_CORE, 32'h0000_0000);
		d = rnd() & 32'h0000_00FF;
		wr(`RFW_OFS_STORE0, d);
		i_core.pulse_pin(`RFW_PIN_MPOR);
		rdchk(`RFW_OFS_STORE0, d, "storage kept");
		i_core.pin(`RFW_PIN_BATT, 1'b0);
		i_core.pulse_pin(`RFW_PIN_MPOR);
		rdchk(`RFW_OFS_STORE0, 32'h0000_0000, "storage lost");
		for (i = 0; i < 8; i++)
		begin
			osc = i % 4;
			ret = i / 4;
			mode = (i + ret) % 4;
			pc = rnd() & 32'h001F_FFFE;
			sp = rnd() & 32'h0000_000F;
			bits = (rnd() & 32'h0000_00FF) | 32'h0000_0001;
			wr(`RFW_OFS_CTRL, 32'((osc << 2) | ret));
			wr(`RFW_OFS_HW_STACK_POINTER, sp);
			wr(`RFW_OFS_INTF, 32'h0000_0000);
			i_core.sleep_wake(bits[7:0], i[0], mode == 0 || mode == 3, mode == 1, pc[20:0], mode == 3);
			check(coreRsp.coreHold, 1'b1, "hold while asleep");
			for (n = 1; n <= 40; n++)
			begin
				@(posedge clk);
				if (coreRsp.pcLoadValid === 1'b1)
					break;
			end
			bound(n, 40);
			check(n, exp_wake(osc, ret), "wake delay");
			check(coreRsp.pcLoadAddr, mode < 2 ? vec(i[0]) : pc, "pc load");
			check(coreRsp.vectorTaken, mode < 2, "vector taken");
			check(coreRsp.coreHold, 1'b0, "hold dropped");
			if (mode < 2)
			begin
				rdchk(`RFW_OFS_TOS, pc, "stack top");
				rdchk(`RFW_OFS_HW_STACK_POINTER, sp + 1, "stack pointer");
			end
			rdchk(`RFW_OFS_INTF, mode == 3 ? 32'h0000_0000 : bits, "wake flags");
			if (mode == 3)
			begin
				rdchk(`RFW_OFS_CORE, 32'h0000_0002, "watchdog flag");
				wr(`RFW_OFS_CORE, 32'h0000_0000);
			end
		end
		wr(`RFW_OFS_CTRL, 32'h0000_0002);
		wr(`RFW_OFS_INTF, 32'h0000_00FF);
		rdchk(`RFW_OFS_INTF, 32'h0000_003F, "small package");
		wr(`RFW_OFS_CTRL, 32'h0000_0000);
		wr(`RFW_OFS_INTF, 32'h0000_00FF);
		rdchk(`RFW_OFS_INTF, 32'h0000_00FF, "full package");
		wr(`RFW_OFS_STORE1, 32'h0000_00A5);
		i_core.warm_reset();
		rdchk(`RFW_OFS_HW_STACK_POINTER, 32'h0000_0000, "warm reset stack pointer");
		rdchk(`RFW_OFS_TOS, 32'h0000_0000, "warm reset stack top");
		rdchk(`RFW_OFS_INTF, 32'h0000_0000, "warm reset flags");
		rdchk(`RFW_OFS_STORE1, 32'h0000_00A5, "warm reset storage");
		print_verdict();
	end

endmodule : reset_flags_wake_init_tb_top
